// ==== core/plpc_pkg.sv ====
// constants for the indicator, loopback and power control block
package plpc_pkg;
  // register indexes; byte address is four times the index
  localparam logic [4:0] IDX_BASIC_CTRL = 5'h00;
  localparam logic [4:0] IDX_MS_CTRL = 5'h09;
  localparam logic [4:0] IDX_PORTAL_CTL = 5'h0D;
  localparam logic [4:0] IDX_PORTAL_DATA = 5'h0E;
  localparam logic [4:0] IDX_REMOTE_LOOP = 5'h11;
  localparam logic [4:0] IDX_CABLE_DIAG = 5'h12;
  localparam logic [4:0] IDX_CROSSOVER = 5'h1C;
  localparam logic [4:0] IDX_STATUS = 5'h15;
  // basic control fields
  localparam int BC_SRESET = 15;
  localparam int BC_LOCAL_LOOP = 14;
  localparam int BC_SPEED_MSB = 6;
  localparam int BC_SPEED_LSB = 13;
  localparam int BC_AN_EN = 12;
  localparam int BC_SLEEP = 11;
  localparam int BC_AN_RESTART = 9;
  localparam int BC_FULL_DUPLEX = 8;
  localparam logic [15:0] BC_RESET_VAL = 16'h1140;
  // other direct register fields
  localparam int MS_MANUAL = 12;
  localparam int MS_MASTER = 11;
  localparam logic [15:0] MS_RESET_VAL = 16'h0000;
  localparam int RL_ENABLE = 8;
  localparam int CD_START = 15;
  localparam int XO_AUTO = 6;
  localparam logic [15:0] XO_RESET_VAL = 16'h0040;
  // portal control: function in the top bits, device in the low bits
  localparam logic [1:0] PORTAL_FN_ADDR = 2'h0;
  localparam logic [4:0] EXT_DEV_VENDOR = 5'h1C;
  localparam logic [4:0] EXT_DEV_AN = 5'h07;
  localparam logic [15:0] EXT_REG_ENERGY_DETECT_SLEEP = 16'h0023;
  localparam logic [15:0] EXT_REG_TENTE = 16'h0004;
  localparam logic [15:0] EXT_REG_EEE_ADV = 16'h003C;
  localparam int EXT_ENERGY_DETECT_SLEEP_BIT = 0;
  localparam int EXT_TENTE_BIT = 10;
  localparam int EXT_EEE_1G_BIT = 2;
  localparam int EXT_EEE_100_BIT = 1;
  // speed codes, bit 6 then bit 13
  localparam logic [1:0] SPD_10 = 2'h0;
  localparam logic [1:0] SPD_100 = 2'h1;
  localparam logic [1:0] SPD_1000 = 2'h2;
  // mode strap codes
  localparam logic [3:0] STRAP_NAND = 4'h4;
  localparam logic [3:0] STRAP_SLEEP = 4'h7;
  // timing
  localparam int CLK_PERIOD_NS = 100;
  localparam int REFRESH_PERIOD_NS = 20000000;
  localparam int REFRESH_BURST_NS = 200000;
  localparam int WAKE_1G_NS = 16000;
  localparam int WAKE_100_NS = 30000;
  localparam int BLINK_HALF_NS = 50000000;
  localparam int REFRESH_PERIOD_CYC = REFRESH_PERIOD_NS / CLK_PERIOD_NS;
  localparam int REFRESH_BURST_CYC = (REFRESH_BURST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WAKE_1G_CYC = WAKE_1G_NS / CLK_PERIOD_NS;
  localparam int WAKE_100_CYC = WAKE_100_NS / CLK_PERIOD_NS;
  localparam int BLINK_HALF_CYC = BLINK_HALF_NS / CLK_PERIOD_NS;
  localparam int CNT_W = 24;
endpackage

// ==== core/plpc_top.sv ====
// indicator, loopback and power control with an ahb-lite register slave
`timescale 1ns/1ps
module plpc_top #(
  parameter int REFRESH_PERIOD_CYC = plpc_pkg::REFRESH_PERIOD_CYC,
  parameter int BLINK_HALF_CYC = plpc_pkg::BLINK_HALF_CYC
) (
  input wire logic sys_clk_i, // 10 MHz clock
  input wire logic rst_n_i, // async reset, active low
  input wire logic hsel_i, // ahb select
  input wire logic [31:0] haddr_i, // ahb address
  input wire logic [1:0] htrans_i, // ahb transfer type
  input wire logic hwrite_i, // ahb write
  input wire logic [2:0] hsize_i, // ahb size
  input wire logic [31:0] hwdata_i, // ahb write data
  input wire logic hready_i, // ahb bus ready
  output logic hreadyout_o, // ahb slave ready
  output logic [31:0] hrdata_o, // ahb read data
  output logic hresp_o, // ahb response, always okay
  input wire logic [3:0] mode_strap_i, // mode straps
  input wire logic indicator_style_strap_i, // low selects tri-color
  input wire logic link_up_i, // line link state
  input wire logic [1:0] link_speed_i, // line speed code
  input wire logic link_full_duplex_i, // line duplex
  input wire logic rx_activity_i, // receive frame seen
  input wire logic tx_activity_i, // transmit frame seen
  input wire logic [7:0] mac_txd_i, // mac transmit data
  input wire logic mac_tx_en_i, // mac transmit enable
  input wire logic [7:0] line_rxd_i, // line receive data
  input wire logic line_rx_dv_i, // line receive valid
  input wire logic tx_lpi_req_i, // mac asks transmit idle
  input wire logic rx_lpi_req_i, // partner sends sleep code
  input wire logic [10:0] chain_pins_i, // txd0..3,gtx,txen,rxdv,rxclk,irq,mdc,mdio
  input wire logic indicator_a_pin_i, // pin level in
  input wire logic indicator_b_pin_i, // pin level in
  output logic indicator_a_pin_o, // pin drive, active low
  output logic indicator_a_pin_oe_n_o, // low while driving
  output logic indicator_b_pin_o, // pin drive, active low
  output logic indicator_b_pin_oe_n_o, // low while driving
  output logic refclk_chain_out_o, // chain result in nand mode
  output logic [7:0] mac_rxd_o, // to mac receive
  output logic mac_rx_dv_o, // to mac receive valid
  output logic [7:0] line_txd_o, // to line transmit
  output logic line_tx_en_o, // to line transmit enable
  output logic an_enable_o, // autonegotiation on
  output logic an_restart_o, // one-cycle restart pulse
  output logic [1:0] forced_speed_o, // forced speed code
  output logic full_duplex_o, // forced duplex
  output logic ms_manual_o, // manual master-slave
  output logic ms_master_o, // forced master
  output logic cable_diag_start_o, // one-cycle diagnostic start
  output logic energy_detect_sleep_o, // energy-detect power-down
  output logic soft_sleep_o, // software power-down
  output logic strap_sleep_o, // strap chip power-down
  output logic ten_te_o, // reduced amplitude 10M
  output logic [1:0] eee_active_o, // {1G,100M} eee in force
  output logic tx_lpi_o, // transmit in idle
  output logic rx_lpi_o, // receive in idle
  output logic refresh_o // refresh burst on line
);
  import plpc_pkg::*;

  localparam int WAKE_1G = WAKE_1G_CYC;

  typedef struct packed {
    logic ph; // data phase pending
    logic [4:0] idx;
    logic wr;
    logic rdy;
    logic [31:0] rdata;
    logic [15:0] bctl;
    logic [15:0] msctl;
    logic [15:0] pctl;
    logic [15:0] paddr;
    logic rloop;
    logic xo_auto;
    logic diag;
    logic energy_detect_sleep_en;
    logic tente;
    logic [1:0] eee_adv;
    logic [1:0] eee_act;
    logic strap_done;
    logic [3:0] mode;
    logic style;
    logic busy;
    logic phase;
    logic [CNT_W-1:0] bcnt;
    logic txl;
    logic rxl;
    logic [CNT_W-1:0] rcnt;
    logic refr;
    logic anr;
    logic sres;
    logic ia;
    logic ib;
    logic oe_n;
    logic chain;
    logic [7:0] mrxd;
    logic mrxdv;
    logic [7:0] ltxd;
    logic ltxen;
    logic eds;
  } plpc_state_t;

  plpc_state_t s_reg, s_next;

  logic normal;
  logic nand_mode;
  logic lloop;
  logic rloop_act;
  logic act_ev;
  logic [1:0] eee_spd;

  // strap decode and path qualifiers
  assign nand_mode = s_reg.strap_done && (s_reg.mode == STRAP_NAND);
  assign normal = s_reg.strap_done && !nand_mode && (s_reg.mode != STRAP_SLEEP)
    && !s_reg.bctl[BC_SLEEP];
  assign lloop = normal && s_reg.bctl[BC_LOCAL_LOOP] && s_reg.bctl[BC_FULL_DUPLEX]
    && !s_reg.bctl[BC_AN_EN];
  assign rloop_act = normal && s_reg.rloop && link_up_i && link_full_duplex_i
    && (link_speed_i == SPD_1000);
  assign act_ev = rx_activity_i || tx_activity_i;
  assign eee_spd = {link_speed_i == SPD_1000, link_speed_i == SPD_100};

  // nand tree over the chain pins in fixed order
  function automatic logic nand_tree(input logic b, input logic a, input logic [10:0] p);
    logic c;
    c = ~(b & a);
    for (int i = 0; i < 11; i++) begin
      c = ~(c & p[i]);
    end
    return c;
  endfunction

  // readback of the extended register selected through the portal
  function automatic logic [15:0] ext_read(input plpc_state_t st);
    logic [15:0] v;
    v = 16'h0000;
    if (st.pctl[4:0] == EXT_DEV_VENDOR && st.paddr == EXT_REG_ENERGY_DETECT_SLEEP) begin
      v[EXT_ENERGY_DETECT_SLEEP_BIT] = st.energy_detect_sleep_en;
    end else if (st.pctl[4:0] == EXT_DEV_VENDOR && st.paddr == EXT_REG_TENTE) begin
      v[EXT_TENTE_BIT] = st.tente;
    end else if (st.pctl[4:0] == EXT_DEV_AN && st.paddr == EXT_REG_EEE_ADV) begin
      v[EXT_EEE_1G_BIT] = st.eee_adv[1];
      v[EXT_EEE_100_BIT] = st.eee_adv[0];
    end
    return v;
  endfunction

  // whole next-state computation
  always_comb begin
    logic [15:0] wd;
    logic [15:0] rv;
    logic on_a;
    logic on_b;
    logic blink;
    wd = hwdata_i[15:0];
    rv = 16'h0000;
    on_a = 1'b0;
    on_b = 1'b0;
    blink = 1'b0;
    s_next = s_reg;
    s_next.anr = 1'b0;
    s_next.diag = 1'b0;
    s_next.sres = 1'b0;
    // straps are caught on the first edge after reset release
    if (!s_reg.strap_done) begin
      s_next.strap_done = 1'b1;
      s_next.mode = mode_strap_i;
      s_next.style = indicator_style_strap_i;
    end
    // ahb address phase; every transfer gets one wait state
    if (!s_reg.ph && hsel_i && htrans_i[1] && hready_i) begin
      s_next.ph = 1'b1;
      s_next.idx = haddr_i[6:2];
      s_next.wr = hwrite_i;
      s_next.rdy = 1'b0;
    end else if (s_reg.ph) begin
      s_next.ph = 1'b0;
      s_next.rdy = 1'b1;
      if (s_reg.wr) begin
        case (s_reg.idx)
          IDX_BASIC_CTRL: begin
            s_next.bctl = wd;
            s_next.bctl[BC_SRESET] = 1'b0;
            s_next.bctl[BC_AN_RESTART] = 1'b0;
            s_next.anr = wd[BC_AN_RESTART];
            s_next.sres = wd[BC_SRESET];
          end
          IDX_MS_CTRL: s_next.msctl = wd;
          IDX_PORTAL_CTL: s_next.pctl = wd;
          IDX_PORTAL_DATA: begin
            if (s_reg.pctl[15:14] == PORTAL_FN_ADDR) begin
              s_next.paddr = wd;
            end else if (s_reg.pctl[4:0] == EXT_DEV_VENDOR && s_reg.paddr == EXT_REG_ENERGY_DETECT_SLEEP) begin
              s_next.energy_detect_sleep_en = wd[EXT_ENERGY_DETECT_SLEEP_BIT];
            end else if (s_reg.pctl[4:0] == EXT_DEV_VENDOR
                && s_reg.paddr == EXT_REG_TENTE) begin
              s_next.tente = wd[EXT_TENTE_BIT];
            end else if (s_reg.pctl[4:0] == EXT_DEV_AN && s_reg.paddr == EXT_REG_EEE_ADV) begin
              s_next.eee_adv = {wd[EXT_EEE_1G_BIT], wd[EXT_EEE_100_BIT]};
            end
          end
          IDX_REMOTE_LOOP: s_next.rloop = wd[RL_ENABLE];
          IDX_CABLE_DIAG: s_next.diag = wd[CD_START] && !s_reg.xo_auto;
          IDX_CROSSOVER: s_next.xo_auto = wd[XO_AUTO];
          default: ;
        endcase
      end
      case (s_reg.idx)
        IDX_BASIC_CTRL: rv = s_reg.bctl;
        IDX_MS_CTRL: rv = s_reg.msctl;
        IDX_PORTAL_CTL: rv = s_reg.pctl;
        IDX_PORTAL_DATA: rv = (s_reg.pctl[15:14] == PORTAL_FN_ADDR) ? s_reg.paddr
          : ext_read(s_reg);
        IDX_REMOTE_LOOP: rv = {7'h00, s_reg.rloop, 8'h00};
        IDX_CROSSOVER: rv = {9'h000, s_reg.xo_auto, 6'h00};
        IDX_STATUS: rv = {4'h0, s_reg.mode, s_reg.style, s_reg.eds, soft_sleep_o,
          strap_sleep_o, s_reg.refr, s_reg.rxl, s_reg.txl, link_up_i};
        default: rv = 16'h0000;
      endcase
      s_next.rdata = {16'h0000, rv};
    end
    // software reset returns registers to defaults, straps kept
    if (s_reg.sres) begin
      s_next.bctl = BC_RESET_VAL;
      s_next.msctl = MS_RESET_VAL;
      s_next.pctl = 16'h0000;
      s_next.paddr = 16'h0000;
      s_next.rloop = 1'b0;
      s_next.xo_auto = XO_RESET_VAL[XO_AUTO];
      s_next.energy_detect_sleep_en = 1'b0;
      s_next.tente = 1'b0;
      s_next.eee_adv = 2'h0;
      s_next.eee_act = 2'h0;
    end
    // advertised eee abilities only take hold on restart
    if (s_reg.anr) begin
      s_next.eee_act = s_reg.eee_adv;
    end
    s_next.eds = normal && s_reg.energy_detect_sleep_en && s_reg.bctl[BC_AN_EN] && !link_up_i;
    // activity blink, restarted by every frame
    if (act_ev && normal) begin
      s_next.busy = 1'b1;
      s_next.phase = 1'b1;
      s_next.bcnt = CNT_W'(BLINK_HALF_CYC - 1);
    end else if (s_reg.busy) begin
      if (s_reg.bcnt == '0) begin
        s_next.phase = !s_reg.phase;
        s_next.busy = !s_reg.phase;
        s_next.bcnt = CNT_W'(BLINK_HALF_CYC - 1);
      end else begin
        s_next.bcnt = s_reg.bcnt - 1'b1;
      end
    end
    // indicator encoding; a pin is low while its light is on
    blink = s_reg.busy && s_reg.phase;
    on_a = 1'b0;
    on_b = 1'b0;
    if (normal && link_up_i) begin
      if (!s_reg.style) begin
        on_b = (link_speed_i != SPD_100) && !blink;
        on_a = (link_speed_i != SPD_1000) && !blink;
      end else begin
        on_b = 1'b1;
        on_a = s_reg.busy && !s_reg.phase;
      end
    end
    s_next.ia = !on_a;
    s_next.ib = !on_b;
    // nand mode turns indicator pins into chain inputs
    // keep pins released until the straps are known, so nand boards never see a drive glitch
    s_next.oe_n = s_reg.strap_done ? nand_mode : s_reg.oe_n;
    s_next.chain = nand_mode ? nand_tree(indicator_b_pin_i, indicator_a_pin_i, chain_pins_i)
      : 1'b0;
    // per-direction idle state; leaves in the cycle after the request drops
    s_next.txl = normal && link_up_i && |(s_reg.eee_act & eee_spd) && tx_lpi_req_i;
    s_next.rxl = normal && link_up_i && |(s_reg.eee_act & eee_spd) && rx_lpi_req_i;
    // refresh burst at the start of each period while transmit idles
    if (s_reg.txl) begin
      s_next.rcnt = (s_reg.rcnt == CNT_W'(REFRESH_PERIOD_CYC - 1)) ? '0 : s_reg.rcnt + 1'b1;
      s_next.refr = (s_next.rcnt < CNT_W'(REFRESH_BURST_CYC));
    end else begin
      s_next.rcnt = '0;
      s_next.refr = 1'b0;
    end
    // data paths; loops steal the path, sleep silences it
    if (!normal) begin
      s_next.mrxd = 8'h00;
      s_next.mrxdv = 1'b0;
      s_next.ltxd = 8'h00;
      s_next.ltxen = 1'b0;
    end else if (lloop) begin
      s_next.mrxd = mac_txd_i;
      s_next.mrxdv = mac_tx_en_i;
      s_next.ltxd = 8'h00;
      s_next.ltxen = 1'b0;
    end else if (rloop_act) begin
      s_next.mrxd = 8'h00;
      s_next.mrxdv = 1'b0;
      s_next.ltxd = line_rxd_i;
      s_next.ltxen = line_rx_dv_i;
    end else begin
      s_next.mrxd = line_rxd_i;
      s_next.mrxdv = line_rx_dv_i;
      s_next.ltxd = mac_txd_i;
      s_next.ltxen = mac_tx_en_i;
    end
  end

  // single state register
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_reg <= '0;
      s_reg.rdy <= 1'b1;
      s_reg.bctl <= BC_RESET_VAL;
      s_reg.msctl <= MS_RESET_VAL;
      s_reg.xo_auto <= XO_RESET_VAL[XO_AUTO];
      s_reg.ia <= 1'b1;
      s_reg.ib <= 1'b1;
      s_reg.oe_n <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  // outputs straight from state
  assign hreadyout_o = s_reg.rdy;
  assign hrdata_o = s_reg.rdata;
  assign hresp_o = 1'b0;
  assign indicator_a_pin_o = s_reg.ia;
  assign indicator_b_pin_o = s_reg.ib;
  assign indicator_a_pin_oe_n_o = s_reg.oe_n;
  assign indicator_b_pin_oe_n_o = s_reg.oe_n;
  assign refclk_chain_out_o = s_reg.chain;
  assign mac_rxd_o = s_reg.mrxd;
  assign mac_rx_dv_o = s_reg.mrxdv;
  assign line_txd_o = s_reg.ltxd;
  assign line_tx_en_o = s_reg.ltxen;
  assign an_enable_o = s_reg.bctl[BC_AN_EN];
  assign an_restart_o = s_reg.anr;
  assign forced_speed_o = {s_reg.bctl[BC_SPEED_MSB], s_reg.bctl[BC_SPEED_LSB]};
  assign full_duplex_o = s_reg.bctl[BC_FULL_DUPLEX];
  assign ms_manual_o = s_reg.msctl[MS_MANUAL];
  assign ms_master_o = s_reg.msctl[MS_MASTER];
  assign cable_diag_start_o = s_reg.diag;
  assign energy_detect_sleep_o = s_reg.eds;
  assign soft_sleep_o = s_reg.bctl[BC_SLEEP];
  assign strap_sleep_o = s_reg.strap_done && (s_reg.mode == STRAP_SLEEP);
  assign ten_te_o = s_reg.tente;
  assign eee_active_o = s_reg.eee_act;
  assign tx_lpi_o = s_reg.txl;
  assign rx_lpi_o = s_reg.rxl;
  assign refresh_o = s_reg.refr;

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);

  AST_DARK_NO_LINK: assert property (!link_up_i |=> indicator_a_pin_o && indicator_b_pin_o)
    else $error("indicator lit without link");
  AST_GIG_ON_B_ONLY: assert property (normal && !s_reg.style && link_up_i
      && link_speed_i == SPD_1000 |=> indicator_a_pin_o)
    else $error("gigabit link lit pin a");
  AST_STEADY_100: assert property (normal && !s_reg.style && link_up_i && !s_reg.busy
      && !act_ev && link_speed_i == SPD_100 |=> !indicator_a_pin_o && indicator_b_pin_o)
    else $error("100M steady link wrong");
  AST_LOCAL_LOOP: assert property (lloop |=> mac_rxd_o == $past(mac_txd_i)
      && mac_rx_dv_o == $past(mac_tx_en_i))
    else $error("local loop data not returned");
  AST_SRESET: assert property (s_reg.sres |=> s_reg.bctl == BC_RESET_VAL && !s_reg.rloop)
    else $error("software reset left state");
  AST_STRAP_STICKY: assert property (strap_sleep_o |=> strap_sleep_o ##1 strap_sleep_o)
    else $error("strap sleep released without reset");
  AST_ENERGY_DETECT_SLEEP_COND: assert property (energy_detect_sleep_o |-> $past(s_reg.bctl[BC_AN_EN])
      && !$past(link_up_i))
    else $error("energy sleep without its conditions");
  AST_TX_WAKE: assert property (tx_lpi_o && !tx_lpi_req_i |-> ##[1:WAKE_1G] !tx_lpi_o)
    else $error("transmit idle wake too slow");
  AST_REFRESH_IN_IDLE: assert property ($rose(refresh_o) |-> $past(tx_lpi_o))
    else $error("refresh burst broken");
  AST_DIAG_GATED: assert property (cable_diag_start_o |-> !s_reg.xo_auto)
    else $error("diagnostic started with crossover on");

  COV_LOCAL_LOOP: cover property (lloop ##1 mac_rx_dv_o);
  COV_REFRESH: cover property ($rose(refresh_o));
  COV_SOFT_SLEEP: cover property ($rose(soft_sleep_o) ##[1:50] $fell(soft_sleep_o));
  COV_NAND: cover property (nand_mode && indicator_a_pin_oe_n_o);
endmodule

// ==== sim/plpc_mac_model.sv ====
// mac-side partner: sends short frames into the transmit path
`timescale 1ns/1ps
module plpc_mac_model (
  input wire logic clk_i, // system clock
  input wire logic rst_n_i, // reset, active low
  input wire logic start_i, // begin one frame
  input wire logic [7:0] seed_i, // first byte of the frame
  output logic [7:0] txd_o, // transmit data
  output logic tx_en_o // transmit enable
);
  int left;
  // eight counting bytes per frame; idle data toggles so a stale byte never looks valid
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      left <= 0;
      tx_en_o <= 1'b0;
      txd_o <= 8'h00;
    end else if (start_i && left == 0 && !tx_en_o) begin
      left <= 7;
      tx_en_o <= 1'b1;
      txd_o <= seed_i;
    end else if (left > 0) begin
      left <= left - 1;
      txd_o <= txd_o + 8'h01;
    end else begin
      tx_en_o <= 1'b0;
      txd_o <= ~txd_o;
    end
  end
endmodule

// ==== sim/tb_phy_led_loopback_power_control.sv ====
// self-checking bench for the indicator, loopback and power control block
`timescale 1ns/1ps
module tb_phy_led_loopback_power_control;
  import plpc_pkg::*;
  localparam int REF_P = 3000;
  logic sys_clk_i, rst_n_i, hsel_i, hwrite_i, hready_i, hreadyout_o, hresp_o, start;
  logic [31:0] haddr_i, hwdata_i, hrdata_o;
  logic [1:0] htrans_i, link_speed_i, forced_speed_o, eee_active_o;
  logic [2:0] hsize_i;
  logic [3:0] mode_strap_i;
  logic indicator_style_strap_i, link_up_i, link_full_duplex_i, rx_activity_i, tx_activity_i;
  logic [7:0] mac_txd_i, line_rxd_i, mac_rxd_o, line_txd_o, seed;
  logic mac_tx_en_i, line_rx_dv_i, tx_lpi_req_i, rx_lpi_req_i, mac_rx_dv_o, line_tx_en_o;
  logic [10:0] chain_pins_i;
  logic indicator_a_pin_i, indicator_b_pin_i, indicator_a_pin_o, indicator_a_pin_oe_n_o;
  logic indicator_b_pin_o, indicator_b_pin_oe_n_o, refclk_chain_out_o, an_enable_o, an_restart_o;
  logic full_duplex_o, ms_manual_o, ms_master_o, cable_diag_start_o, energy_detect_sleep_o;
  logic soft_sleep_o, strap_sleep_o, ten_te_o, tx_lpi_o, rx_lpi_o, refresh_o;
  int fails, n_compared, n_restart, n_diag, n_rx, cnt;
  logic [7:0] q[$];
  assign hready_i = hreadyout_o;

  plpc_top #(.REFRESH_PERIOD_CYC(REF_P), .BLINK_HALF_CYC(8)) dut (.sys_clk_i, .rst_n_i, .hsel_i,
    .haddr_i, .htrans_i, .hwrite_i, .hsize_i, .hwdata_i, .hready_i, .hreadyout_o, .hrdata_o,
    .hresp_o, .mode_strap_i, .indicator_style_strap_i, .link_up_i, .link_speed_i,
    .link_full_duplex_i, .rx_activity_i, .tx_activity_i, .mac_txd_i, .mac_tx_en_i, .line_rxd_i,
    .line_rx_dv_i, .tx_lpi_req_i, .rx_lpi_req_i, .chain_pins_i, .indicator_a_pin_i,
    .indicator_b_pin_i, .indicator_a_pin_o, .indicator_a_pin_oe_n_o, .indicator_b_pin_o,
    .indicator_b_pin_oe_n_o, .refclk_chain_out_o, .mac_rxd_o, .mac_rx_dv_o, .line_txd_o,
    .line_tx_en_o, .an_enable_o, .an_restart_o, .forced_speed_o, .full_duplex_o, .ms_manual_o,
    .ms_master_o, .cable_diag_start_o, .energy_detect_sleep_o, .soft_sleep_o, .strap_sleep_o,
    .ten_te_o, .eee_active_o, .tx_lpi_o, .rx_lpi_o, .refresh_o);
  plpc_mac_model mac (.clk_i(sys_clk_i), .rst_n_i, .start_i(start), .seed_i(seed),
    .txd_o(mac_txd_i), .tx_en_o(mac_tx_en_i));

  // 100 ns clock
  initial begin
    sys_clk_i = 1'b0;
    forever #50 sys_clk_i = ~sys_clk_i;
  end

  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task cyc(input int n);
    repeat (n) @(posedge sys_clk_i);
  endtask
  // bounded wait for the slave's ready, sampled before the edge's own updates land
  task wait_ready;
    int n;
    n = 0;
    @(posedge sys_clk_i);
    while (hreadyout_o !== 1'b1 && n < 100) begin
      @(posedge sys_clk_i);
      n++;
    end
    if (n >= 100) chk(32'h0, 32'h1);
  endtask
  // one single ahb transfer; select stays up with idle trans so no double drive at an edge
  task ahb(input logic wr, input logic [4:0] idx, input logic [15:0] wd, output logic [31:0] rd);
    hsel_i <= 1'b1;
    haddr_i <= {25'h0, idx, 2'h0};
    htrans_i <= 2'h2;
    hwrite_i <= wr;
    wait_ready();
    htrans_i <= 2'h0;
    hwdata_i <= {16'h0, wd};
    wait_ready();
    rd = hrdata_o;
  endtask
  task wr(input logic [4:0] idx, input logic [15:0] d);
    logic [31:0] x;
    ahb(1'b1, idx, d, x);
  endtask
  task rdc(input logic [4:0] idx, input logic [15:0] e);
    logic [31:0] x;
    ahb(1'b0, idx, 16'h0, x);
    chk(x, {16'h0, e});
  endtask
  task ext(input logic [4:0] dev, input logic [15:0] r, input logic [15:0] d);
    wr(IDX_PORTAL_CTL, {PORTAL_FN_ADDR, 9'h0, dev});
    wr(IDX_PORTAL_DATA, r);
    wr(IDX_PORTAL_CTL, {2'h1, 9'h0, dev});
    wr(IDX_PORTAL_DATA, d);
  endtask
  task reset(input logic [3:0] s);
    rst_n_i <= 1'b0;
    mode_strap_i <= s;
    cyc(3);
    rst_n_i <= 1'b1;
    cyc(2);
  endtask
  task wrap_up;
    $display("compared %0d, mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // reference model: every byte the mac sends must come back in order while wrapped
  always @(posedge sys_clk_i) begin
    if (an_restart_o === 1'b1) n_restart++;
    if (cable_diag_start_o === 1'b1) n_diag++;
    if (mac_rx_dv_o === 1'b1) begin
      n_rx++;
      if (q.size() == 0) chk(32'h1, 32'h0);
      else chk(mac_rxd_o, q.pop_front());
    end
    if (mac_tx_en_i === 1'b1) q.push_back(mac_txd_i);
  end

  // whole run is about 3200 cycles; six times that means a hang
  initial begin
    cyc(20000);
    fails++;
    wrap_up();
  end

  initial begin
    {rst_n_i, hsel_i, htrans_i, hwrite_i, haddr_i, hwdata_i, mode_strap_i, start, seed} = '0;
    {indicator_style_strap_i, link_up_i, link_speed_i, rx_activity_i, tx_activity_i} = '0;
    {line_rxd_i, line_rx_dv_i, tx_lpi_req_i, rx_lpi_req_i, chain_pins_i} = '0;
    {fails, n_compared, n_restart, n_diag, n_rx} = '0;
    {indicator_a_pin_i, indicator_b_pin_i, link_full_duplex_i} = 3'h7;
    hsize_i = 3'h2;
    void'($urandom(99073));
    @(posedge sys_clk_i);
    reset(4'h0);
    rdc(IDX_BASIC_CTRL, BC_RESET_VAL);
    rdc(IDX_CROSSOVER, XO_RESET_VAL);
    rdc(5'h1F, 16'h0);
    chk({energy_detect_sleep_o, eee_active_o}, 3'h0);
    ext(EXT_DEV_VENDOR, EXT_REG_ENERGY_DETECT_SLEEP, 16'h0001);
    ext(EXT_DEV_VENDOR, EXT_REG_TENTE, 16'h0400);
    cyc(2);
    chk({energy_detect_sleep_o, ten_te_o}, 2'h3);
    // tri-color encoding for 10, 100, 1000 and no link
    for (int s = 0; s < 4; s++) begin
      link_up_i <= (s < 3);
      link_speed_i <= s[1:0];
      cyc(3);
      chk({indicator_b_pin_o, indicator_a_pin_o}, (s == 3) ? 2'h3 : {s == 1, s == 2});
    end
    link_up_i <= 1'b1;
    link_speed_i <= SPD_1000;
    cyc(3);
    chk(energy_detect_sleep_o, 1'b0);
    tx_activity_i <= 1'b1;
    cyc(1);
    tx_activity_i <= 1'b0;
    cyc(3);
    chk(indicator_b_pin_o, 1'b1);
    cyc(20);
    chk(indicator_b_pin_o, 1'b0);
    ext(EXT_DEV_AN, EXT_REG_EEE_ADV, 16'h0006);
    cyc(2);
    chk(eee_active_o, 2'h0);
    wr(IDX_BASIC_CTRL, 16'h1340);
    cyc(3);
    chk({n_restart[1:0], eee_active_o}, 4'h7);
    rdc(IDX_BASIC_CTRL, BC_RESET_VAL);
    tx_lpi_req_i <= 1'b1;
    cyc(3);
    chk({tx_lpi_o, rx_lpi_o}, 2'h2);
    cnt = 0;
    repeat (REF_P) begin
      @(posedge sys_clk_i);
      if (refresh_o === 1'b1) cnt++;
    end
    chk(cnt, REFRESH_BURST_CYC);
    rx_lpi_req_i <= 1'b1;
    cyc(2);
    chk({tx_lpi_o, rx_lpi_o}, 2'h3);
    tx_lpi_req_i <= 1'b0;
    cnt = 0;
    while (tx_lpi_o !== 1'b0 && cnt < WAKE_1G_CYC) begin
      @(posedge sys_clk_i);
      cnt++;
    end
    chk({tx_lpi_o, rx_lpi_o}, 2'h1);
    rx_lpi_req_i <= 1'b0;
    // diagnostic start refused while crossover automatic, taken once it is off
    wr(IDX_BASIC_CTRL, 16'h9140);
    wr(IDX_CABLE_DIAG, 16'h8000);
    wr(IDX_CROSSOVER, 16'h0000);
    wr(IDX_CABLE_DIAG, 16'h8000);
    cyc(2);
    chk(n_diag, 1);
    wr(IDX_BASIC_CTRL, 16'h9940);
    cyc(3);
    rdc(IDX_BASIC_CTRL, BC_RESET_VAL);
    wr(IDX_BASIC_CTRL, 16'h1940);
    cyc(2);
    chk(soft_sleep_o, 1'b1);
    wr(IDX_BASIC_CTRL, BC_RESET_VAL);
    cyc(2);
    chk(soft_sleep_o, 1'b0);
    wr(IDX_MS_CTRL, 16'h1000);
    chk({ms_manual_o, ms_master_o}, 2'h2);
    // local loopback at each forced speed with a random frame
    for (int sp = 0; sp < 3; sp++) begin
      wr(IDX_BASIC_CTRL, 16'h4100 | (sp[1] ? 16'h0040 : 16'h0) | (sp[0] ? 16'h2000 : 16'h0));
      cyc(2);
      chk({an_enable_o, full_duplex_o, forced_speed_o}, {2'h1, sp[1:0]});
      seed <= 8'($urandom);
      start <= 1'b1;
      cyc(1);
      start <= 1'b0;
      cyc(12);
      chk(q.size(), 0);
    end
    chk(n_rx, 24);
    // remote loop on the live gigabit full-duplex link
    wr(IDX_BASIC_CTRL, 16'h0140);
    wr(IDX_REMOTE_LOOP, 16'h0100);
    line_rxd_i <= 8'h5A;
    line_rx_dv_i <= 1'b1;
    cyc(2);
    chk({line_tx_en_o, line_txd_o}, 9'h15A);
    line_rx_dv_i <= 1'b0;
    reset(STRAP_SLEEP);
    cyc(5);
    chk(strap_sleep_o, 1'b1);
    reset(STRAP_NAND);
    chk({strap_sleep_o, indicator_a_pin_oe_n_o, indicator_b_pin_oe_n_o}, 3'h3);
    // chain of all ones flips eleven times from a low first stage
    chain_pins_i <= 11'h7FF;
    cyc(2);
    chk(refclk_chain_out_o, 1'b1);
    indicator_b_pin_i <= 1'b0;
    cyc(2);
    chk(refclk_chain_out_o, 1'b0);
    wrap_up();
  end
endmodule
